// File: core/mbd_detect_irq.sv
// Purpose : mic presence and hook switch detection with sticky interrupts
// Assumes : comparator outputs synchronous to clk_i; simple strobe register port
// Notes   : gpio_o shows one filtered detection result, chosen in control
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

// Function
// - Presence debounce filtering applies only when its enable bit is 1.
// - Hook press flagged only after 10 consecutive samples above threshold.
// - Extra hook debounce filtering applies when its enable bit is 1.
// - Detection results can be shown live on a general purpose pin.
// - With polarity 1, release flagged after 10 consecutive samples below.
// - Pin changes carry the same detection delays as the flags.
module mbd_detect_irq
  import mbd_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     pres_above_i,
  input  wire logic                     hook_above_i,
  input  wire logic [mbd_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [mbd_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [mbd_pkg::DATA_W-1:0] rd_data_o,
  output logic                          irq_o,
  output logic                          gpio_o
);

  // ==========================================================================
  // state
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [EV_W-1:0]   flag_r;
  logic [EV_W-1:0]   flag_nxt;
  logic [EV_W-1:0]   en_r;
  logic [EV_W-1:0]   en_nxt;
  logic [SDIV_W-1:0] div_r;
  logic [SDIV_W-1:0] div_nxt;
  logic              sample_r;
  logic              sample_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              irq_nxt;
  logic              gpio_nxt;
  logic              pres_state;
  logic              hook_state;

  // ==========================================================================
  // register decode
  wire wr_ctrl_w   = wr_i && (addr_i == REG_CTRL);
  wire wr_clear_w  = wr_i && (addr_i == REG_CLEAR);
  wire wr_enable_w = wr_i && (addr_i == REG_ENABLE);

  wire [EV_W-1:0] live_w   = {hook_state, pres_state};
  wire [EV_W-1:0] pol_w    = {ctrl_r[CTRL_HOOK_POL], ctrl_r[CTRL_PRES_POL]};
  wire [EV_W-1:0] set_w    = live_w ^ pol_w;
  wire [EV_W-1:0] clr_w    = wr_clear_w ? wr_data_i[EV_W-1:0] : EV_RST;

  function automatic logic [DATA_W-1:0] pad_fn(input logic [CTRL_W-1:0] v);
    pad_fn = {{(DATA_W-CTRL_W){1'b0}}, v};
  endfunction : pad_fn

  // ==========================================================================
  // sample strobe
  wire div_end_w = div_r == SDIV_W'(SAMPLE_CYCLES - 1);

  always_comb begin
    div_nxt    = div_end_w ? '0 : div_r + 8'h01;
    sample_nxt = div_end_w;
  end

  // ==========================================================================
  // filters
  // presence debounce gated by enable
  mbd_filter #(
    .BASE_N (PRES_BASE_N),
    .DB_N   (PRES_DB_N)
  ) u_pres_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (sample_r),
    .raw_i     (pres_above_i),
    .db_en_i   (ctrl_r[CTRL_PRES_DB]),
    .state_o   (pres_state)
  );

  mbd_filter #(
    .BASE_N (HOOK_BASE_N),
    .DB_N   (HOOK_DB_N)
  ) u_hook_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (sample_r),
    .raw_i     (hook_above_i),
    .db_en_i   (ctrl_r[CTRL_HOOK_DB]),
    .state_o   (hook_state)
  );

  // ==========================================================================
  // registers and flags
  always_comb begin
    ctrl_nxt = wr_ctrl_w ? wr_data_i[CTRL_W-1:0] : ctrl_r;
    en_nxt   = wr_enable_w ? wr_data_i[EV_W-1:0] : en_r;
    flag_nxt = (flag_r & ~clr_w) | set_w;
  end

  // ==========================================================================
  // read mux, pin and interrupt
  always_comb begin
    rd_data_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        REG_CTRL:   rd_data_nxt = pad_fn(ctrl_r);
        REG_STATUS: rd_data_nxt = pad_fn(CTRL_W'(flag_r));
        REG_ENABLE: rd_data_nxt = pad_fn(CTRL_W'(en_r));
        REG_LIVE:   rd_data_nxt = pad_fn(CTRL_W'(live_w));
        default:    rd_data_nxt = '0;
      endcase
    end
    gpio_nxt = ctrl_r[CTRL_GPIO_SEL] ? hook_state : pres_state;
    irq_nxt  = |(flag_nxt & en_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r    <= CTRL_RST;
      en_r      <= EV_RST;
      flag_r    <= EV_RST;
      div_r     <= '0;
      sample_r  <= 1'b0;
      rd_data_o <= '0;
      irq_o     <= 1'b0;
      gpio_o    <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      en_r      <= en_nxt;
      flag_r    <= flag_nxt;
      div_r     <= div_nxt;
      sample_r  <= sample_nxt;
      rd_data_o <= rd_data_nxt;
      irq_o     <= irq_nxt;
      gpio_o    <= gpio_nxt;
    end
  end

endmodule : mbd_detect_irq

// File: core/mbd_filter.sv
// Purpose : consecutive-sample filter for one bias current comparator
// Assumes : sample_i is a one-cycle strobe, raw_i synchronous to clk_i
// Notes   : state flips only after the required run of disagreeing samples
`timescale 1ns/1ns
module mbd_filter
  import mbd_pkg::*;
#(
  parameter logic [7:0] BASE_N = 8'h01,
  parameter logic [7:0] DB_N   = 8'h01
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sample_i,
  input  wire logic raw_i,
  input  wire logic db_en_i,
  output logic      state_o
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             state_r;
  logic             state_nxt;
  wire  [CNT_W-1:0] need_w  = db_en_i ? DB_N : BASE_N;
  wire              diff_w  = raw_i != state_r;
  wire  [CNT_W-1:0] cnt_inc = cnt_r + 8'h01;
  wire              run_w   = diff_w && (cnt_inc >= need_w);

  // ==========================================================================
  // run counter
  always_comb begin
    cnt_nxt   = cnt_r;
    state_nxt = state_r;
    if (sample_i) begin
      if (!diff_w || run_w) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_inc;
      end
      if (run_w) begin
        state_nxt = raw_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_r   <= '0;
      state_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  assign state_o = state_r;

endmodule : mbd_filter

// File: core/mbd_pkg.sv
// Purpose : shared constants for the mic bias current detect interrupt block
// Assumes : 250 MHz system clock, comparator inputs synchronous to clk_i
// Notes   : register map, field positions, reset values and filter counts
package mbd_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned SAMPLE_PERIOD_NS = 1000;
  localparam int unsigned SAMPLE_CYCLES    = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam int unsigned SDIV_W           = 8;

  // ==========================================================================
  // filter sample counts
  localparam int unsigned CNT_W            = 8;
  localparam logic [7:0]  PRES_BASE_N      = 8'h04;
  localparam logic [7:0]  PRES_DB_N        = 8'h40;
  localparam logic [7:0]  HOOK_BASE_N      = 8'h0A;
  localparam logic [7:0]  HOOK_DB_N        = 8'h28;

  // ==========================================================================
  // register bus
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 16;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h01;
  localparam logic [7:0]  REG_CLEAR        = 8'h02;
  localparam logic [7:0]  REG_ENABLE       = 8'h03;
  localparam logic [7:0]  REG_LIVE         = 8'h04;

  // control fields
  localparam int unsigned CTRL_PRES_POL    = 0;
  localparam int unsigned CTRL_HOOK_POL    = 1;
  localparam int unsigned CTRL_PRES_DB     = 2;
  localparam int unsigned CTRL_HOOK_DB     = 3;
  localparam int unsigned CTRL_GPIO_SEL    = 4;
  localparam int unsigned CTRL_W           = 5;
  localparam logic [4:0]  CTRL_RST         = 5'h00;

  // event fields (status, clear, enable, live)
  localparam int unsigned EV_PRES          = 0;
  localparam int unsigned EV_HOOK          = 1;
  localparam int unsigned EV_W             = 2;
  localparam logic [1:0]  EV_RST           = 2'h0;

endpackage : mbd_pkg

// File: verif/mbd_detect_irq_bench.sv
// Purpose : self-checking bench for mbd_detect_irq
// Assumes : 4 ns clock
// Notes   : host sequence of insertion and hook switch
`timescale 1ns/1ns
module mbd_detect_irq_bench;
  import mbd_pkg::*;
  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 8'h00;
  logic [DATA_W-1:0] wr_data_i = 16'h0000;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              ins = 1'b0;
  logic              prs = 1'b0;
  logic              bnc = 1'b0;
  wire  [DATA_W-1:0] rd_data_o;
  wire               irq_o, gpio_o, pa, ha;
  int                fails = 0;
  int                tests_run = 0;
  initial forever #2 clk_i = ~clk_i;
  mbd_jack_model jack (.clk_i(clk_i), .insert_i(ins), .press_i(prs), .bounce_i(bnc),
    .pres_above_o(pa), .hook_above_o(ha));
  mbd_detect_irq dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pres_above_i(pa),
    .hook_above_i(ha), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .irq_o(irq_o), .gpio_o(gpio_o));
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", n, exp, got);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i      <= 1'b0;
  endtask : wr
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk(n, rd_data_o, exp);
  endtask : rchk
  task automatic t_regs;
    rchk("ctrl", REG_CTRL, 16'h0000);
    rchk("unmapped", 8'h05, 16'h0000);
    rchk("clear reads zero", REG_CLEAR, 16'h0000);
    wr(REG_ENABLE, 16'h0003);
    wr(REG_LIVE, 16'h0003);
    rchk("enable", REG_ENABLE, 16'h0003);
    rchk("live", REG_LIVE, 16'h0000);
    $display("regs done");
  endtask : t_regs
  task automatic t_insert;
    @(posedge clk_i);
    ins <= 1'b1;
    bnc <= 1'b1;
    repeat (2000) @(posedge clk_i);
    rchk("bounce", REG_STATUS, 16'h0000);
    bnc <= 1'b0;
    repeat (1300) @(posedge clk_i);
    rchk("inserted", REG_STATUS, 16'h0001);
    chk("irq", {15'h0, irq_o}, 16'h0001);
    wr(REG_CLEAR, 16'h0001);
    rchk("held", REG_STATUS, 16'h0001);
    wr(REG_CTRL, 16'h0011);
    wr(REG_CLEAR, 16'h0001);
    rchk("cleared", REG_STATUS, 16'h0000);
    chk("irq off", {15'h0, irq_o}, 16'h0000);
    $display("insert done");
  endtask : t_insert
  task automatic t_hook;
    @(posedge clk_i);
    prs <= 1'b1;
    bnc <= 1'b1;
    repeat (2000) @(posedge clk_i);
    bnc <= 1'b0;
    repeat (1700) @(posedge clk_i);
    chk("press early", {15'h0, gpio_o}, 16'h0000);
    repeat (1100) @(posedge clk_i);
    rchk("press", REG_STATUS, 16'h0002);
    chk("press pin", {15'h0, gpio_o}, 16'h0001);
    wr(REG_CTRL, 16'h0013);
    wr(REG_CLEAR, 16'h0002);
    prs <= 1'b0;
    repeat (1700) @(posedge clk_i);
    rchk("release early", REG_STATUS, 16'h0000);
    repeat (1100) @(posedge clk_i);
    rchk("release", REG_STATUS, 16'h0002);
    chk("release pin", {15'h0, gpio_o}, 16'h0000);
    $display("hook done");
  endtask : t_hook
  task automatic t_hook_db;
    wr(REG_CTRL, 16'h0019);
    wr(REG_CLEAR, 16'h0002);
    prs <= 1'b1;
    repeat (9700) @(posedge clk_i);
    chk("db early", {15'h0, gpio_o}, 16'h0000);
    repeat (600) @(posedge clk_i);
    rchk("db press", REG_STATUS, 16'h0002);
    $display("debounce done");
  endtask : t_hook_db
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_insert();
    t_hook();
    t_hook_db();
    stop_test();
  end
endmodule : mbd_detect_irq_bench

// File: verif/mbd_jack_model.sv
// Purpose : jack with microphone and hook switch
// Assumes : comparators already synchronous
// Notes   : bounce chatters every 300 cycles
`timescale 1ns/1ns
module mbd_jack_model (
  input  wire logic clk_i,
  input  wire logic insert_i,
  input  wire logic press_i,
  input  wire logic bounce_i,
  output logic      pres_above_o,
  output logic      hook_above_o
);
  logic [8:0] tick_r = 9'h000;
  logic       chat_r = 1'b0;
  always_ff @(posedge clk_i) begin
    tick_r <= (tick_r == 9'h12B) ? 9'h000 : tick_r + 9'h001;
    if (tick_r == 9'h000) chat_r <= ~chat_r;
  end
  assign pres_above_o = (bounce_i && !press_i) ? chat_r : insert_i;
  assign hook_above_o = press_i && (bounce_i ? chat_r : 1'b1);
endmodule : mbd_jack_model

// File: verif/mbd_monitor.sv
// Purpose : port checker for mbd_detect_irq
// Assumes : one clock, synchronous reset
// Notes   : shadows control and enable writes
`timescale 1ns/1ns
module mbd_monitor
  import mbd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              pres_above_i,
  input  wire logic              hook_above_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] rd_data_o,
  input  wire logic              irq_o,
  input  wire logic              gpio_o
);
  logic [4:0]  ctl_r;
  logic [1:0]  en_r;
  logic        hq_r, pq_r;
  logic [15:0] rh_r, rp_r;
  wire  [15:0] lim_h = ctl_r[CTRL_HOOK_DB] ? 16'h2616 : 16'h08CA;
  wire  [15:0] lim_p = ctl_r[CTRL_PRES_DB] ? 16'h3D86 : 16'h02EE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // shadows and run lengths
  always_ff @(posedge clk_i) begin
    hq_r <= hook_above_i;
    pq_r <= pres_above_i;
    rh_r <= (sys_rst_i || hq_r != hook_above_i) ? 16'h0000 : rh_r + 16'h0001;
    rp_r <= (sys_rst_i || pq_r != pres_above_i) ? 16'h0000 : rp_r + 16'h0001;
    if (sys_rst_i) begin
      ctl_r <= CTRL_RST;
      en_r  <= EV_RST;
    end else if (wr_i && addr_i == REG_CTRL) begin
      ctl_r <= wr_data_i[4:0];
    end else if (wr_i && addr_i == REG_ENABLE) begin
      en_r  <= wr_data_i[1:0];
    end
  end
  // ==========================================================================
  // assertions
  hook_delay_a: assert property (
    $changed(gpio_o) && $past(ctl_r[4]) && $past(ctl_r[4], 2)
    |-> $past(hook_above_i) == gpio_o && $past(rh_r) >= lim_h) else $error("hook early");
  pres_delay_a: assert property (
    $changed(gpio_o) && !$past(ctl_r[4]) && !$past(ctl_r[4], 2)
    |-> $past(pres_above_i) == gpio_o && $past(rp_r) >= lim_p) else $error("pres early");
  irq_gate_a: assert property (
    irq_o |-> en_r != 2'h0) else $error("irq not enabled");
  live_pin_a: assert property (
    $past(rd_i && addr_i == REG_LIVE) |-> rd_data_o[$past(ctl_r[4])] == gpio_o)
    else $error("pin differs");
  rd_idle_a: assert property (
    !$past(rd_i) |-> rd_data_o == 16'h0000) else $error("data without read");
  rd_unmap_a: assert property (
    $past(rd_i && addr_i > REG_LIVE) |-> rd_data_o == 16'h0000) else $error("unmapped");
  rd_upper_a: assert property (
    $past(rd_i) |-> rd_data_o[15:5] == 11'h000) else $error("upper bits");
  cover property ($rose(gpio_o) && ctl_r[4]);
  cover property ($rose(irq_o));
  cover property ($fell(gpio_o));
endmodule : mbd_monitor
bind mbd_detect_irq mbd_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .pres_above_i(pres_above_i), .hook_above_i(hook_above_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .irq_o(irq_o), .gpio_o(gpio_o));
